// ---- pes_afe_model.sv ----
`timescale 1ns/1ns
`include "pes_regs.vh"
module pes_afe_model (
   input wire clk,
   input wire rst_b,
   input wire measReq,
   input wire [3:0] measStep,
   input wire [1:0] loadKind,
   input wire [15:0] classCur,
   input wire [1:0] delay,
   output reg measDone,
   output reg [15:0] measCurrent,
   output reg [15:0] measVoltage,
   output reg [3:0] fingerCnt,
   output reg [3:0] probeCnt,
   output reg [3:0] firstFinger
);
   reg [1:0] cnt_q;
   reg after8_q;
   reg [15:0] iVal;
   reg [15:0] vVal;
   // load kinds: 0 valid 25k, 1 leaky switch, 2 second source, 3 capacitive
   always @* begin
      iVal = 16'h0;
      vVal = 16'h0;
      case (measStep)
         `PES_STEP_FCHK_I: iVal = loadKind == 2'h1 ? 16'h01f4 : 16'h0;
         `PES_STEP_DRV4: begin
            iVal = after8_q && loadKind == 2'h3 ? 16'h0834 : 16'h0640;
            vVal = `PES_V4;
         end
         `PES_STEP_DRV8: begin
            iVal = 16'h0c80;
            vVal = `PES_V8;
         end
         `PES_STEP_FINGER, `PES_STEP_LFINGER: iVal = classCur;
         default: iVal = 16'h0;
      endcase
      if (loadKind == 2'h2 && vVal != 16'h0) vVal = vVal + 16'h03e8;
   end
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {measDone, cnt_q, after8_q, measCurrent, measVoltage} <= 36'h0;
         {fingerCnt, probeCnt, firstFinger} <= 12'h0;
      end else begin
         measDone <= 1'b0;
         // outside a done pulse the lines carry junk that flips every cycle
         measCurrent <= ~measCurrent;
         measVoltage <= ~measVoltage;
         if (measReq && !measDone && cnt_q != delay) cnt_q <= cnt_q + 2'h1;
         if (measReq && !measDone && cnt_q == delay) begin
            cnt_q <= 2'h0;
            measDone <= 1'b1;
            measCurrent <= iVal;
            measVoltage <= vVal;
            after8_q <= measStep == `PES_STEP_DRV8 || (after8_q && measStep != `PES_STEP_FCHK_I);
            if (measStep == `PES_STEP_CRESET) begin
               probeCnt <= fingerCnt;
               fingerCnt <= 4'h0;
            end
            if (measStep == `PES_STEP_FINGER || measStep == `PES_STEP_LFINGER) begin
               fingerCnt <= fingerCnt + 4'h1;
               if (fingerCnt == 4'h0) firstFinger <= measStep;
            end
         end
      end
   end
endmodule

// ---- pes_port_sequencer.v ----
`timescale 1ns/1ns
`include "pes_regs.vh"
module pes_port_sequencer (
   input wire clk,
   input wire rst_b,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg measReq,
   output reg [3:0] measStep,
   output reg [1:0] measPort,
   input wire measDone,
   input wire [15:0] measCurrent,
   input wire [15:0] measVoltage,
   output reg [3:0] switchOn,
   output reg [31:0] pairsetLimit,
   output reg [15:0] fourPairLimit,
   output reg hostAlert_b
);
   localparam S_IDLE = 10'h001;
   localparam S_FCHKI = 10'h002;
   localparam S_FCHKV = 10'h004;
   localparam S_DET4A = 10'h008;
   localparam S_DET8 = 10'h010;
   localparam S_DET4B = 10'h020;
   localparam S_CC = 10'h040;
   localparam S_PROBE = 10'h080;
   localparam S_CRST = 10'h100;
   localparam S_CPON = 10'h200;

   reg [9:0] state_q;
   reg [7:0] mode_q;
   reg [1:0] fourPair_q;
   reg [3:0] detEn_q;
   reg [3:0] clsEn_q;
   reg [3:0] pbPend_q;
   reg [3:0] evDisc_q;
   reg [3:0] evCls_q;
   reg [3:0] evFault_q;
   reg [11:0] detRes_q;
   reg [15:0] clsCode_q;
   reg [15:0] reqCls_q;
   reg [15:0] grant_q;
   reg [7:0] cause_q;
   reg [15:0] budget_q;
   reg [1:0] dual_q;
   reg [3:0] discDone_q;
   reg [1:0] cur_q;
   reg pwr_q;
   reg sec_q;
   reg [2:0] fcnt_q;
   reg [2:0] nf_q;
   reg [3:0] pendGrant_q;
   reg [3:0] pendCode_q;
   reg [15:0] i4a_q;
   reg [15:0] i8_q;
   reg [2:0] band1_q;
   reg [2:0] band3_q;
   reg [31:0] rdData;
   reg [31:0] wMask;
   reg [3:0] stepNow;
   reg [1:0] pickPb;
   reg [1:0] pickDs;
   reg anyPb;
   reg anyDs;
   reg [3:0] reqNow;
   reg [3:0] budNow;
   integer i;

   wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire measOk = measDone & measReq;
   wire grp = cur_q[1];
   wire isFour = fourPair_q[grp];
   wire [15:0] dI = i8_q - i4a_q;
   wire [22:0] dIlo = {7'h00, dI} * `PES_R_LO;
   wire [22:0] dIhi = {7'h00, dI} * `PES_R_HI;
   wire [22:0] dVn = {7'h00, `PES_DV} * `PES_R_DEN;

   function [15:0] absd;
      input [15:0] a;
      input [15:0] b;
      begin
         absd = (a > b) ? a - b : b - a;
      end
   endfunction

   function [2:0] band;
      input [15:0] c;
      begin
         if (c < `PES_CLS_T0) band = 3'h0;
         else if (c < `PES_CLS_T1) band = 3'h1;
         else if (c < `PES_CLS_T2) band = 3'h2;
         else if (c < `PES_CLS_T3) band = 3'h3;
         else if (c < `PES_CLS_T4) band = 3'h4;
         else band = 3'h7;
      end
   endfunction

   function [2:0] fingers;
      input [3:0] g;
      begin
         if (g <= 4'h3) fingers = 3'h1;
         else if (g == 4'h4) fingers = 3'h2;
         else if (g <= 4'h6) fingers = 3'h4;
         else fingers = 3'h5;
      end
   endfunction

   // detection outcome: event, fault or onward to check/probe
   task finishDet;
      input [2:0] code;
      begin
         detRes_q[cur_q*3 +: 3] <= code;
         fcnt_q <= 3'h0;
         if (code != `PES_DET_VALID) begin
            state_q <= S_IDLE;
            if (pwr_q) begin
               cause_q[cur_q*2 +: 2] <= `PES_CAUSE_INVDET;
               evFault_q[cur_q] <= 1'b1;
            end else begin
               discDone_q[cur_q] <= 1'b1;
               if (!isFour) evDisc_q[cur_q] <= 1'b1;
            end
         end else if (isFour && !sec_q) begin
            state_q <= S_CC;
         end else begin
            if (!isFour && !pwr_q) evDisc_q[cur_q] <= 1'b1;
            state_q <= S_PROBE;
         end
      end
   endtask

   always @* begin
      case (state_q)
         S_FCHKI: stepNow = `PES_STEP_FCHK_I;
         S_FCHKV: stepNow = `PES_STEP_FCHK_V;
         S_DET4A: stepNow = `PES_STEP_DRV4;
         S_DET8: stepNow = `PES_STEP_DRV8;
         S_DET4B: stepNow = `PES_STEP_DRV4;
         S_CC: stepNow = `PES_STEP_CC;
         S_PROBE: stepNow = `PES_STEP_FINGER;
         S_CRST: stepNow = `PES_STEP_CRESET;
         S_CPON: stepNow = (fcnt_q == 3'h0) ? `PES_STEP_LFINGER : `PES_STEP_FINGER;
         default: stepNow = `PES_STEP_IDLE;
      endcase
   end

   // lowest numbered port wins; power-on waits for the idle engine
   always @* begin
      pickPb = 2'h0;
      pickDs = 2'h0;
      anyPb = 1'b0;
      anyDs = 1'b0;
      for (i = 3; i >= 0; i = i - 1) begin
         if (pbPend_q[i]) begin
            pickPb = i[1:0];
            anyPb = 1'b1;
         end
         if (mode_q[i*2 +: 2] == `PES_MODE_SEMI && detEn_q[i] && clsEn_q[i]
             && !discDone_q[i] && !switchOn[i]) begin
            pickDs = i[1:0];
            anyDs = 1'b1;
         end
      end
   end

   always @* begin
      if (band1_q == 3'h7) reqNow = `PES_CLS_INVALID;
      else if (band1_q < 3'h4) reqNow = {1'b0, band1_q};
      else if (band3_q == 3'h7) reqNow = `PES_CLS_INVALID;
      else reqNow = 4'h4 + {1'b0, band3_q};
      budNow = budget_q[cur_q*4 +: 4];
   end

   always @* begin
      wMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      case (wb_adr_i)
         `PES_A_MODE: rdData = {22'h000000, fourPair_q, mode_q};
         `PES_A_ENABLE: rdData = {24'h000000, clsEn_q, detEn_q};
         `PES_A_PB_ON: rdData = 32'h00000000;
         `PES_A_EVENT: rdData = {20'h00000, evFault_q, evCls_q, evDisc_q};
         `PES_A_DETCLS: rdData = {clsCode_q[15:12], 1'b0, detRes_q[11:9],
                                  clsCode_q[11:8], 1'b0, detRes_q[8:6],
                                  clsCode_q[7:4], 1'b0, detRes_q[5:3],
                                  clsCode_q[3:0], 1'b0, detRes_q[2:0]};
         `PES_A_CLSRES: rdData = {grant_q[15:12], reqCls_q[15:12], grant_q[11:8],
                                  reqCls_q[11:8], grant_q[7:4], reqCls_q[7:4],
                                  grant_q[3:0], reqCls_q[3:0]};
         `PES_A_CAUSE: rdData = {24'h000000, cause_q};
         `PES_A_BUDGET: rdData = {16'h0000, budget_q};
         `PES_A_LIMIT2: rdData = pairsetLimit;
         `PES_A_LIMIT4: rdData = {16'h0000, fourPairLimit};
         `PES_A_PWRSTAT: rdData = {26'h0000000, dual_q, switchOn};
         default: rdData = 32'h00000000;
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         state_q <= S_IDLE;
         mode_q <= 8'h00;
         fourPair_q <= 2'h0;
         detEn_q <= 4'h0;
         clsEn_q <= 4'h0;
         pbPend_q <= 4'h0;
         evDisc_q <= 4'h0;
         evCls_q <= 4'h0;
         evFault_q <= 4'h0;
         detRes_q <= 12'h000;
         clsCode_q <= 16'h0000;
         reqCls_q <= 16'h0000;
         grant_q <= 16'h0000;
         cause_q <= 8'h00;
         budget_q <= 16'h0000;
         dual_q <= 2'h0;
         discDone_q <= 4'h0;
         cur_q <= 2'h0;
         pwr_q <= 1'b0;
         sec_q <= 1'b0;
         fcnt_q <= 3'h0;
         nf_q <= 3'h1;
         pendGrant_q <= 4'h0;
         pendCode_q <= 4'h0;
         i4a_q <= 16'h0000;
         i8_q <= 16'h0000;
         band1_q <= 3'h0;
         band3_q <= 3'h0;
         measReq <= 1'b0;
         measStep <= `PES_STEP_IDLE;
         measPort <= 2'h0;
         switchOn <= 4'h0;
         pairsetLimit <= 32'h00000000;
         fourPairLimit <= 16'h0000;
         hostAlert_b <= 1'b1;
      end else begin
         wb_ack_o <= wbReq;
         if (wbReq && !wb_we_i) begin
            wb_dat_o <= rdData;
            if (wb_adr_i == `PES_A_EVENT) begin
               evDisc_q <= 4'h0;
               evCls_q <= 4'h0;
               evFault_q <= 4'h0;
            end
         end
         if (wbReq && wb_we_i) begin
            case (wb_adr_i)
               `PES_A_MODE: begin
                  mode_q <= (mode_q & ~wMask[7:0]) | (wb_dat_i[7:0] & wMask[7:0]);
                  if (wb_sel_i[1]) fourPair_q <= wb_dat_i[9:8];
               end
               `PES_A_ENABLE: if (wb_sel_i[0]) begin
                  detEn_q <= wb_dat_i[3:0];
                  clsEn_q <= wb_dat_i[7:4];
                  discDone_q <= 4'h0;
               end
               `PES_A_PB_ON: if (wb_sel_i[0]) pbPend_q <= pbPend_q | wb_dat_i[3:0];
               `PES_A_BUDGET: budget_q <= (budget_q & ~wMask[15:0]) | (wb_dat_i[15:0] & wMask[15:0]);
               `PES_A_LIMIT2: pairsetLimit <= (pairsetLimit & ~wMask) | (wb_dat_i & wMask);
               `PES_A_LIMIT4: fourPairLimit <= (fourPairLimit & ~wMask[15:0])
                                               | (wb_dat_i[15:0] & wMask[15:0]);
               default: ;
            endcase
         end
         for (i = 0; i < 4; i = i + 1)
            if (mode_q[i*2 +: 2] == `PES_MODE_SHUT) switchOn[i] <= 1'b0;
         hostAlert_b <= ~(|{evDisc_q, evCls_q, evFault_q});
         measReq <= (state_q != S_IDLE) & ~measOk;
         measStep <= stepNow;
         measPort <= cur_q;
         case (state_q)
            S_IDLE: begin
               sec_q <= 1'b0;
               fcnt_q <= 3'h0;
               if (anyPb) begin
                  cur_q <= pickPb;
                  pwr_q <= 1'b1;
                  // a pushbutton written in this very cycle must not be lost
                  pbPend_q[pickPb] <= wbReq && wb_we_i && wb_adr_i == `PES_A_PB_ON
                                      && wb_sel_i[0] && wb_dat_i[pickPb];
                  cause_q[pickPb*2 +: 2] <= `PES_CAUSE_NONE;
                  state_q <= S_FCHKI;
               end else if (anyDs) begin
                  cur_q <= pickDs;
                  pwr_q <= 1'b0;
                  state_q <= S_FCHKI;
               end
            end
            S_FCHKI: if (measOk) begin
               if (measCurrent > `PES_FET_IMAX) finishDet(`PES_DET_SWF);
               else state_q <= S_FCHKV;
            end
            S_FCHKV: if (measOk) begin
               if (measVoltage > `PES_FET_VMAX) finishDet(`PES_DET_SWF);
               else state_q <= S_DET4A;
            end
            S_DET4A: if (measOk) begin
               i4a_q <= measCurrent;
               if (absd(measVoltage, `PES_V4) > `PES_VTOL) finishDet(`PES_DET_CONT);
               else state_q <= S_DET8;
            end
            S_DET8: if (measOk) begin
               i8_q <= measCurrent;
               if (absd(measVoltage, `PES_V8) > `PES_VTOL) finishDet(`PES_DET_CONT);
               else state_q <= S_DET4B;
            end
            S_DET4B: if (measOk) begin
               if (absd(measVoltage, `PES_V4) > `PES_VTOL) finishDet(`PES_DET_CONT);
               else if (absd(measCurrent, i4a_q) > `PES_CAP_TOL) finishDet(`PES_DET_CAP);
               else if (i8_q <= i4a_q || dIhi < dVn) finishDet(`PES_DET_OPEN);
               else if (dIlo > dVn) finishDet(`PES_DET_LOWR);
               else finishDet(`PES_DET_VALID);
            end
            S_CC: if (measOk) begin
               dual_q[grp] <= (measCurrent > `PES_CC_TH);
               if (!pwr_q) evDisc_q[cur_q] <= 1'b1;
               fcnt_q <= 3'h0;
               state_q <= S_PROBE;
            end
            S_PROBE: if (measOk) begin
               if (fcnt_q == 3'h0) band1_q <= band(measCurrent);
               if (fcnt_q == 3'h2) begin
                  band3_q <= band(measCurrent);
                  state_q <= S_CRST;
               end
               fcnt_q <= fcnt_q + 3'h1;
            end
            S_CRST: if (measOk) begin
               fcnt_q <= 3'h0;
               reqCls_q[cur_q*4 +: 4] <= reqNow;
               if (!pwr_q) begin
                  clsCode_q[cur_q*4 +: 4] <= reqNow;
                  evCls_q[cur_q] <= 1'b1;
                  if (isFour && dual_q[grp] && !sec_q) begin
                     sec_q <= 1'b1;
                     cur_q <= cur_q ^ 2'h1;
                     state_q <= S_FCHKI;
                  end else begin
                     discDone_q[cur_q] <= 1'b1;
                     state_q <= S_IDLE;
                  end
               end else if ((isFour && !dual_q[grp] && reqNow >= 4'h5
                             && reqNow != `PES_CLS_INVALID)
                            || (isFour && dual_q[grp] && budNow == 4'h0)) begin
                  cause_q[cur_q*2 +: 2] <= `PES_CAUSE_INSUF;
                  evFault_q[cur_q] <= 1'b1;
                  state_q <= S_IDLE;
               end else if (reqNow == `PES_CLS_INVALID) begin
                  cause_q[cur_q*2 +: 2] <= `PES_CAUSE_CLSERR;
                  evFault_q[cur_q] <= 1'b1;
                  state_q <= S_IDLE;
               // class 4+ demoted to class 3
               end else if (reqNow >= 4'h4 && budNow < 4'h4) begin
                  pendGrant_q <= 4'h3;
                  pendCode_q <= `PES_CLS_LIMITED;
                  nf_q <= 3'h1;
                  state_q <= S_CPON;
               end else begin
                  pendGrant_q <= (reqNow < budNow) ? reqNow : budNow;
                  pendCode_q <= (reqNow < budNow) ? reqNow : budNow;
                  nf_q <= fingers((reqNow < budNow) ? reqNow : budNow);
                  state_q <= S_CPON;
               end
            end
            S_CPON: if (measOk) begin
               if (measCurrent > `PES_CLS_OC || band(measCurrent) == 3'h7) begin
                  cause_q[cur_q*2 +: 2] <= `PES_CAUSE_CLSERR;
                  evFault_q[cur_q] <= 1'b1;
                  state_q <= S_IDLE;
               end else if (fcnt_q + 3'h1 >= nf_q) begin
                  grant_q[cur_q*4 +: 4] <= pendGrant_q;
                  clsCode_q[cur_q*4 +: 4] <= pendCode_q;
                  switchOn[cur_q] <= 1'b1;
                  state_q <= S_IDLE;
               end else begin
                  fcnt_q <= fcnt_q + 3'h1;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule

// ---- pes_port_sequencer_sva.sv ----
`timescale 1ns/1ns
`include "pes_regs.vh"
module pes_port_sequencer_sva (
   input wire clk,
   input wire rst_b,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire measReq,
   input wire [3:0] measStep,
   input wire measDone,
   input wire [3:0] switchOn,
   input wire [31:0] pairsetLimit,
   input wire hostAlert_b
);
   reg [3:0] lastStep_q;
   wire rdEvt = wb_ack_o && !wb_we_i && wb_adr_i == `PES_A_EVENT;
   wire wrLim = wb_ack_o && wb_we_i && wb_adr_i == `PES_A_LIMIT2 && wb_sel_i == 4'hf;
   // last step the front end finished, for order checks
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lastStep_q <= `PES_STEP_IDLE;
      end else if (measReq && measDone) begin
         lastStep_q <= measStep;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_pb_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `PES_A_PB_ON |->
      wb_dat_o == 32'h0) else $error("pushbutton read not zero");
   chk_alert_hold: assert property (!hostAlert_b && !rdEvt |=> !hostAlert_b)
      else $error("alert released without event read");
   chk_alert_rise: assert property ($rose(hostAlert_b) && $past(rst_b) |->
      $past(rdEvt) || $past(rdEvt, 2)) else $error("alert rose without event read");
   chk_fet_first: assert property ($rose(measReq) && measStep == `PES_STEP_DRV4 |->
      lastStep_q == `PES_STEP_FCHK_V || lastStep_q == `PES_STEP_DRV8)
      else $error("drive 4V out of order");
   chk_drv8_order: assert property ($rose(measReq) && measStep == `PES_STEP_DRV8 |->
      lastStep_q == `PES_STEP_DRV4) else $error("drive 8V not after 4V");
   chk_creset_order: assert property ($rose(measReq) && measStep == `PES_STEP_CRESET |->
      lastStep_q == `PES_STEP_FINGER) else $error("class reset not after finger");
   chk_long_first: assert property ($rose(measReq) && measStep == `PES_STEP_LFINGER |->
      lastStep_q == `PES_STEP_CRESET) else $error("long finger not first");
   chk_switch_after: assert property ($rose(switchOn[0]) |->
      lastStep_q == `PES_STEP_FINGER || lastStep_q == `PES_STEP_LFINGER)
      else $error("switch on before class power-on");
   chk_req_stands: assert property (measReq && !measDone |=> measReq && $stable(measStep))
      else $error("measurement request dropped early");
   chk_limit_live: assert property (wrLim |=> pairsetLimit == $past(wb_dat_i) &&
      switchOn == $past(switchOn)) else $error("limit write not applied live");
endmodule

// ---- pes_regs.vh ----
`ifndef PES_REGS_VH
`define PES_REGS_VH

// register byte offsets
`define PES_A_MODE 8'h00
`define PES_A_ENABLE 8'h04
`define PES_A_PB_ON 8'h08
`define PES_A_EVENT 8'h0c
`define PES_A_DETCLS 8'h10
`define PES_A_CLSRES 8'h14
`define PES_A_CAUSE 8'h18
`define PES_A_BUDGET 8'h1c
`define PES_A_LIMIT2 8'h20
`define PES_A_LIMIT4 8'h24
`define PES_A_PWRSTAT 8'h28

// port mode field values
`define PES_MODE_SHUT 2'h0
`define PES_MODE_SEMI 2'h2

// detect_result codes
`define PES_DET_NONE 3'h0
`define PES_DET_VALID 3'h1
`define PES_DET_OPEN 3'h2
`define PES_DET_LOWR 3'h3
`define PES_DET_CAP 3'h4
`define PES_DET_CONT 3'h5
`define PES_DET_SWF 3'h6

// class_result_code special values
`define PES_CLS_LIMITED 4'hc
`define PES_CLS_INVALID 4'hf

// power_on_fault_event causes
`define PES_CAUSE_NONE 2'h0
`define PES_CAUSE_INVDET 2'h1
`define PES_CAUSE_CLSERR 2'h2
`define PES_CAUSE_INSUF 2'h3

// measurement step codes to the analog front end
`define PES_STEP_IDLE 4'h0
`define PES_STEP_FCHK_I 4'h1
`define PES_STEP_FCHK_V 4'h2
`define PES_STEP_DRV4 4'h3
`define PES_STEP_DRV8 4'h4
`define PES_STEP_CC 4'h5
`define PES_STEP_FINGER 4'h6
`define PES_STEP_LFINGER 4'h7
`define PES_STEP_CRESET 4'h8

// thresholds: voltage lsb 1 mV, detection current lsb 100 nA
`define PES_V4 16'h0fa0
`define PES_V8 16'h1f40
`define PES_DV 16'h0fa0
`define PES_FET_IMAX 16'h0064
`define PES_FET_VMAX 16'h03e8
`define PES_VTOL 16'h0190
`define PES_CAP_TOL 16'h00c8
`define PES_R_DEN 23'h000014
`define PES_R_LO 23'h000026
`define PES_R_HI 23'h000035
`define PES_CC_TH 16'h0320
// class current bands, lsb 0.1 mA
`define PES_CLS_T0 16'h0032
`define PES_CLS_T1 16'h0082
`define PES_CLS_T2 16'h00d2
`define PES_CLS_T3 16'h012c
`define PES_CLS_T4 16'h01c2
`define PES_CLS_OC 16'h0258

`endif

// ---- testbench.sv ----
`timescale 1ns/1ns
`include "pes_regs.vh"
module testbench;
   reg clk, rst_b, wbCyc, wbStb, wbWe;
   reg [7:0] wbAdr;
   reg [31:0] wbDatI, rd, k;
   wire [31:0] wbDatO, pairsetLimit;
   wire wbAck, measReq, measDone, hostAlert_b;
   wire [3:0] measStep, switchOn, fingerCnt, probeCnt, firstFinger;
   wire [1:0] measPort;
   wire [15:0] measCurrent, measVoltage, fourPairLimit;
   reg [1:0] loadKind, delay, bud, cls;
   reg [15:0] classCur;
   reg [11:0] evt;
   integer failCount, nTests, kd;
   pes_port_sequencer u_pes_port_sequencer (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .measReq(measReq), .measStep(measStep),
      .measPort(measPort), .measDone(measDone), .measCurrent(measCurrent),
      .measVoltage(measVoltage), .switchOn(switchOn), .pairsetLimit(pairsetLimit),
      .fourPairLimit(fourPairLimit), .hostAlert_b(hostAlert_b));
   pes_afe_model u_pes_afe_model (.clk(clk), .rst_b(rst_b), .measReq(measReq),
      .measStep(measStep), .loadKind(loadKind), .classCur(classCur), .delay(delay),
      .measDone(measDone), .measCurrent(measCurrent), .measVoltage(measVoltage),
      .fingerCnt(fingerCnt), .probeCnt(probeCnt), .firstFinger(firstFinger));
   function [15:0] curOf(input [1:0] c);
      curOf = c == 2'h0 ? 16'h0014 : c == 2'h1 ? 16'h005a : c == 2'h2 ? 16'h00aa : 16'h00fa;
   endfunction
   task check(input string nm, input [31:0] seen, input [31:0] want);
      nTests = nTests + 1;
      if (seen !== want) begin
         failCount = failCount + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task tally_and_finish;
      if (failCount == 0 && nTests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task xfer(input [7:0] a, input w, input [31:0] d);
      integer n;
      @(posedge clk);
      {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {1'b1, 1'b1, w, a, d};
      n = 0;
      @(posedge clk);
      while (wbAck !== 1'b1 && n < 20) begin
         @(posedge clk);
         n = n + 1;
      end
      if (n >= 20) failCount = failCount + 1;
      rd = wbDatO;
      {wbCyc, wbStb, wbWe} <= 3'h0;
   endtask
   task waitSig(input sw);
      integer n;
      n = 0;
      while ((sw ? switchOn[0] !== 1'b1 : hostAlert_b !== 1'b0) && n < 3000) begin
         @(posedge clk);
         n = n + 1;
      end
      if (n >= 3000) failCount = failCount + 1;
   endtask
   task waitEvt(input [11:0] want);
      integer n;
      evt = 12'h0;
      n = 0;
      while ((evt & want) !== want && n < 400) begin
         xfer(`PES_A_EVENT, 1'b0, 32'h0);
         evt = evt | rd[11:0];
         n = n + 1;
      end
   endtask
   task disc(input [1:0] kk, input [2:0] det);
      reg [11:0] e;
      e = kk == 2'h0 ? 12'h011 : 12'h001;
      loadKind <= kk;
      delay <= $urandom % 4;
      xfer(`PES_A_MODE, 1'b1, {30'h0, `PES_MODE_SEMI});
      xfer(`PES_A_ENABLE, 1'b1, 32'h11);
      waitSig(1'b0);
      check("alert low", hostAlert_b, 0);
      waitEvt(e);
      check("events", evt, e);
      xfer(`PES_A_DETCLS, 1'b0, 32'h0);
      check("detect code", rd[2:0], det);
      if (kk == 2'h0) check("class code", rd[7:4], cls);
      xfer(`PES_A_CLSRES, 1'b0, 32'h0);
      if (kk == 2'h0) check("requested", rd[3:0], cls);
      check("alert high", hostAlert_b, 1);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #1000000;
      failCount = failCount + 1;
      tally_and_finish;
   end
   initial begin
      {rst_b, wbCyc, wbStb, wbWe, wbAdr, wbDatI} = 44'h0;
      {loadKind, delay, classCur} = 20'h0;
      failCount = 0;
      nTests = 0;
      k = $urandom(72);
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      check("alert reset", hostAlert_b, 1);
      xfer(8'h40, 1'b1, $urandom);
      xfer(8'h40, 1'b0, 32'h0);
      check("unmapped", rd, 0);
      cls = $urandom % 4;
      classCur <= curOf(cls);
      disc(2'h0, `PES_DET_VALID);
      // host sets the budget only after the probe result is known
      bud = $urandom % 4;
      xfer(`PES_A_BUDGET, 1'b1, {30'h0, bud});
      loadKind <= 2'h2;
      xfer(`PES_A_PB_ON, 1'b1, 32'h1);
      xfer(`PES_A_PB_ON, 1'b0, 32'h0);
      check("pb reads 0", rd, 0);
      waitEvt(12'h100);
      check("fault event", evt[8], 1);
      xfer(`PES_A_CAUSE, 1'b0, 32'h0);
      check("cause", rd[1:0], `PES_CAUSE_INVDET);
      check("switch off", switchOn[0], 0);
      loadKind <= 2'h0;
      xfer(`PES_A_PB_ON, 1'b1, 32'h1);
      waitSig(1'b1);
      check("switch on", switchOn[0], 1);
      check("probe fingers", probeCnt, 3);
      check("on fingers", fingerCnt, 1);
      check("long first", firstFinger, `PES_STEP_LFINGER);
      xfer(`PES_A_CLSRES, 1'b0, 32'h0);
      check("granted", rd[7:4], bud < cls ? bud : cls);
      k = $urandom;
      xfer(`PES_A_LIMIT2, 1'b1, k);
      check("limit live", pairsetLimit, k);
      check("still on", switchOn[0], 1);
      k = $urandom;
      xfer(`PES_A_LIMIT4, 1'b1, k);
      check("limit4 live", fourPairLimit, k[15:0]);
      check("meas port", measPort, 0);
      for (kd = 1; kd < 4; kd = kd + 1) begin
         xfer(`PES_A_MODE, 1'b1, {30'h0, `PES_MODE_SHUT});
         disc(kd, kd == 1 ? `PES_DET_SWF : kd == 2 ? `PES_DET_CONT : `PES_DET_CAP);
      end
      tally_and_finish;
   end
endmodule
bind pes_port_sequencer pes_port_sequencer_sva u_pes_port_sequencer_sva (.clk(clk),
   .rst_b(rst_b), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .measReq(measReq),
   .measStep(measStep), .measDone(measDone), .switchOn(switchOn),
   .pairsetLimit(pairsetLimit), .hostAlert_b(hostAlert_b));
